// file: cgd_pkg.sv
package cgd_pkg;
	localparam int unsigned MCLK_HZ = 125_000_000;
	localparam int unsigned MCLK_MHZ = MCLK_HZ / 1_000_000;
	localparam int unsigned PLL_LOCK_TIME_US = 250;
	// Worked in microseconds times MHz so the product stays inside 32 bits
	localparam int unsigned PLL_LOCK_CYCLES = PLL_LOCK_TIME_US * MCLK_MHZ;
	localparam int unsigned PLL_LOCK_W = 15;
	localparam logic [7:0] PLL_MIN_MHZ = 8'h18;
	localparam logic [7:0] PLL_MAX_MHZ = 8'h43;
	localparam int unsigned PLL_ACC_W = 15;
	localparam int unsigned DIV_W = 16;
	localparam logic [DIV_W-1:0] DIV_MIN = 16'h0002;
	localparam int unsigned CTC_W = 13;
	localparam int unsigned FTC_W = 5;
	localparam logic [1:0] MID_LAST = 2'h2;
	localparam logic [6:0] SLOW_LAST = 7'h63;
	localparam logic [14:0] SEC_LAST = 15'h7FFF;
	localparam int unsigned NUM_PINS = 13;
	localparam int unsigned NUM_DIG = 8;
	localparam int unsigned NUM_ANA = 4;
	localparam int unsigned P_IMO = 0;
	localparam int unsigned P_XTAL = 1;
	localparam int unsigned P_FAB = 2;
	localparam int unsigned P_AUX = 3;
	localparam int unsigned P_LSO = 11;
	localparam int unsigned P_WATCH = 12;

	typedef enum logic [1:0]
	{
		SYS_IMO = 2'b00,
		SYS_XTAL = 2'b01,
		SYS_FAB = 2'b10,
		SYS_PLL = 2'b11
	} cgd_sys_src_t;

	typedef enum logic [1:0]
	{
		USB_FAB48 = 2'b00,
		USB_DBL_IMO = 2'b01,
		USB_DBL_FAB = 2'b10,
		USB_DBL_XTAL = 2'b11
	} cgd_usb_src_t;
endpackage : cgd_pkg

// file: cgd_div_if.sv
`timescale 1ns/1ns
interface cgd_div_if;
	logic [7:0] src_en;
	logic [2:0] sel;
	logic [15:0] ratio;
	logic [1:0] skew;
	logic clk_out;
	logic tick;

	modport ctl
	(
		output src_en, sel, ratio, skew,
		input clk_out, tick
	);
	modport div
	(
		input src_en, sel, ratio, skew,
		output clk_out, tick
	);
endinterface : cgd_div_if

// file: cgd_divider.sv
`timescale 1ns/1ns
module cgd_divider
(
	input wire logic mclk,
	input wire logic sys_rst,
	cgd_div_if.div d
);
	import cgd_pkg::*;

	typedef struct packed
	{
		logic [DIV_W-1:0] cnt;
		logic [DIV_W-1:0] ratio;
		logic [2:0] sel;
		logic [1:0] skew;
		logic lvl;
		logic [2:0] dly;
		logic out;
		logic tick;
	} cgd_div_st_t;

	cgd_div_st_t s;
	cgd_div_st_t next_s;

	always_comb
	begin
		next_s = s;
		next_s.tick = 1'b0;
		if (d.src_en[s.sel])
		begin
			if (s.cnt >= s.ratio - 16'h0001)
			begin
				// New settings load only at the period boundary, so no runt pulse
				next_s.cnt = '0;
				next_s.tick = 1'b1;
				next_s.sel = d.sel;
				next_s.ratio = (d.ratio < DIV_MIN) ? DIV_MIN : d.ratio;
				next_s.skew = d.skew;
			end
			else
			begin
				next_s.cnt = s.cnt + 16'h0001;
			end
		end
		// High for the first ratio/2 counts, rounded down, gives 50% duty at even ratios
		next_s.lvl = (next_s.cnt < (next_s.ratio >> 1));
		next_s.dly = {s.dly[1:0], s.lvl};
		// Skew delays the edge by whole mclk cycles away from digital edges
		next_s.out = (s.skew == 2'b00) ? s.lvl : s.dly[s.skew - 2'b01];
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s <= '{cnt: '0, ratio: DIV_MIN, sel: 3'h0, skew: 2'h0, lvl: 1'b1, dly: 3'h0, out: 1'b0, tick: 1'b0};
		end
		else
		begin
			s <= next_s;
		end
	end

	assign d.clk_out = s.out;
	assign d.tick = s.tick;
endmodule : cgd_divider

// file: cgd_clock_gen.sv
`timescale 1ns/1ns
// What this block does
// - Loop output must be 24 to 67 MHz
// - Input and feedback dividers give 4032 ratios
// - Loop locks within 250 us, sets lock bit
// - Loop reference: main osc, crystal or fabric
// - Lock indication can be routed as interrupt
// - Low-speed osc gives 1, 33, 100 kHz
// - Central tick counter: free 13-bit, 1 kHz
// - Central counter stops in hibernate or debug halt
// - Firmware may clear central counter anytime
// - Central counter gives periodic wakeups, optional interrupt
// - Fast counter: 5-bit, 100 kHz, terminal count
// - Fast counter optional interrupt at terminal count
// - Mid tick is fast tick divided by three
// - Watch crystal gives one-second interrupt
// - Eight extra fabric clocks feed digital dividers
// - System clock source, 16-bit bus divider, cpu
// - Eight digital, four skewed analog 16-bit dividers
// - Divider: 8-input select, ratio two up, 50% at even ratios
// - Digital divider output can cascade into another
// - USB gets 48 MHz direct or doubled
// - Loop output unusable until lock bit set
module cgd_clock_gen
#(
	parameter int unsigned LOCK_CYCLES = cgd_pkg::PLL_LOCK_CYCLES
)
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic internal_main_osc,
	input wire logic fast_crystal_osc,
	input wire logic fabric_clk,
	input wire logic [7:0] fabric_aux_clk,
	input wire logic low_speed_internal_osc,
	input wire logic watch_crystal_osc,
	input wire logic pll_enable,
	input wire logic [1:0] pll_ref_sel,
	input wire logic [7:0] pll_ref_mhz,
	input wire logic [5:0] pll_in_div,
	input wire logic [5:0] pll_fb_mult,
	input wire logic lock_route_en,
	input wire cgd_pkg::cgd_sys_src_t sys_src_sel,
	input wire logic [15:0] bus_ratio,
	input wire logic [7:0][2:0] dig_sel,
	input wire logic [7:0][15:0] dig_ratio,
	input wire logic [3:0][2:0] ana_sel,
	input wire logic [3:0][15:0] ana_ratio,
	input wire logic [3:0][1:0] ana_skew,
	input wire cgd_pkg::cgd_usb_src_t usb_src_sel,
	input wire logic hibernate,
	input wire logic debug_halt,
	input wire logic ctc_clear,
	input wire logic ctc_wake_en,
	input wire logic ctc_irq_en,
	input wire logic [3:0] ctc_period_sel,
	input wire logic ftc_enable,
	input wire logic ftc_irq_en,
	input wire logic [4:0] ftc_terminal,
	output logic pll_lock,
	output logic pll_cfg_ok,
	output logic pll_lock_irq,
	output logic pll_clk_en,
	output logic tick_clock_slow,
	output logic tick_clock_mid,
	output logic tick_clock_fast,
	output logic [12:0] central_tick_counter,
	output logic ctc_wake,
	output logic ctc_irq,
	output logic [4:0] fast_tick_count,
	output logic ftc_wake,
	output logic ftc_irq,
	output logic rtc_second_irq,
	output logic bus_clk,
	output logic cpu_clk,
	output logic [7:0] dig_clk,
	output logic [3:0] ana_clk,
	output logic usb_clk_en
);
	import cgd_pkg::*;

	typedef struct packed
	{
		logic [NUM_PINS-1:0] sync1;
		logic [NUM_PINS-1:0] sync2;
		logic [NUM_PINS-1:0] sync3;
		logic [NUM_PINS-1:0] stab;
		logic [NUM_PINS-1:0] rise;
		logic [NUM_PINS-1:0] chg;
		logic [PLL_LOCK_W-1:0] lock_cnt;
		logic lock;
		logic cfg_ok;
		logic [1:0] ref_sel;
		logic [5:0] in_div;
		logic [5:0] fb_mult;
		logic [PLL_ACC_W-1:0] acc;
		logic pll_tick;
		logic lock_irq;
		logic sys_en;
		logic [1:0] mid_cnt;
		logic [6:0] slow_cnt;
		logic t_fast;
		logic t_mid;
		logic t_slow;
		logic [CTC_W-1:0] ctc;
		logic ctc_wake;
		logic ctc_irq;
		logic [FTC_W-1:0] ftc;
		logic ftc_wake;
		logic ftc_irq;
		logic [14:0] sec_cnt;
		logic sec_irq;
		logic usb_en;
		logic bus_clk;
		logic [NUM_DIG-1:0] dig_clk;
		logic [NUM_ANA-1:0] ana_clk;
	} cgd_state_t;

	cgd_state_t s;
	cgd_state_t next_s;

	logic [NUM_PINS-1:0] pins;
	logic bus_out;
	logic [NUM_DIG-1:0] dig_out;
	logic [NUM_DIG-1:0] dig_tick;
	logic [NUM_ANA-1:0] ana_out;

	// Product of two small unsigned codes, truncated to 14 bits
	function automatic logic [13:0] cgd_mul(input logic [7:0] a, input logic [6:0] b);
		cgd_mul = 14'({7'h00, a} * {8'h00, b});
	endfunction : cgd_mul

	// Reference frequency times feedback, compared against the band times input divide
	// Input divide runs to 64, so it needs seven bits
	function automatic logic cgd_in_band(input logic [7:0] ref_mhz, input logic [5:0] fb, input logic [6:0] idiv);
		logic [13:0] prod;
		logic [13:0] lo;
		logic [13:0] hi;
		prod = cgd_mul(ref_mhz, {1'b0, fb});
		lo = cgd_mul(PLL_MIN_MHZ, idiv);
		hi = cgd_mul(PLL_MAX_MHZ, idiv);
		cgd_in_band = (fb != 6'h00) && (prod >= lo) && (prod <= hi);
	endfunction : cgd_in_band

	assign pins = {watch_crystal_osc, low_speed_internal_osc, fabric_aux_clk, fabric_clk, fast_crystal_osc,
		internal_main_osc};

	always_comb
	begin
		logic ref_rise;
		logic [PLL_ACC_W-1:0] sum;
		logic [PLL_ACC_W-1:0] lim;
		logic [CTC_W-1:0] ctc_mask;
		ref_rise = 1'b0;
		sum = '0;
		lim = '0;
		ctc_mask = '0;
		next_s = s;

		// Pin inputs: a change counts once the second and third stage agree
		next_s.sync1 = pins;
		next_s.sync2 = s.sync1;
		next_s.sync3 = s.sync2;
		for (int i = 0; i < NUM_PINS; i++)
		begin
			if (s.sync2[i] == s.sync3[i])
			begin
				next_s.stab[i] = s.sync3[i];
			end
		end
		next_s.rise = next_s.stab & ~s.stab;
		next_s.chg = next_s.stab ^ s.stab;

		// Multiplying loop; ref_sel, in_div and fb_mult are taken while the loop is off and held while it runs; pll_ref_mhz is used live
		next_s.lock_irq = 1'b0;
		next_s.pll_tick = 1'b0;
		if (!pll_enable)
		begin
			// Firmware turns the loop off before low power; that drops lock here
			next_s.lock_cnt = '0;
			next_s.lock = 1'b0;
			next_s.acc = '0;
			next_s.ref_sel = pll_ref_sel;
			next_s.in_div = pll_in_div;
			next_s.fb_mult = pll_fb_mult;
			next_s.cfg_ok = cgd_in_band(pll_ref_mhz, pll_fb_mult, {1'b0, pll_in_div} + 7'h01);
		end
		else if (!s.lock)
		begin
			if (s.lock_cnt >= PLL_LOCK_W'(LOCK_CYCLES - 1))
			begin
				next_s.lock = 1'b1;
				next_s.lock_irq = lock_route_en;
			end
			else
			begin
				next_s.lock_cnt = s.lock_cnt + 15'h0001;
			end
		end
		else
		begin
			// Rate model: out MHz = ref MHz * mult / (div+1), paced against mclk
			sum = s.acc + PLL_ACC_W'(cgd_mul(pll_ref_mhz, {1'b0, s.fb_mult}));
			lim = PLL_ACC_W'(cgd_mul(8'(MCLK_MHZ), {1'b0, s.in_div} + 7'h01));
			if (sum >= lim)
			begin
				next_s.acc = sum - lim;
				next_s.pll_tick = s.cfg_ok;
			end
			else
			begin
				next_s.acc = sum;
			end
		end

		// System clock; until lock the loop's own reference stands in for it
		case (s.ref_sel)
			2'b00: ref_rise = s.rise[P_IMO];
			2'b01: ref_rise = s.rise[P_XTAL];
			2'b10: ref_rise = s.rise[P_FAB];
			default: ref_rise = s.rise[P_IMO];
		endcase
		case (sys_src_sel)
			SYS_IMO: next_s.sys_en = s.rise[P_IMO];
			SYS_XTAL: next_s.sys_en = s.rise[P_XTAL];
			SYS_FAB: next_s.sys_en = s.rise[P_FAB];
			SYS_PLL: next_s.sys_en = s.lock ? s.pll_tick : ref_rise;
			default: next_s.sys_en = s.rise[P_IMO];
		endcase

		// Low-speed ticks from the 100 kHz oscillator pin
		next_s.t_fast = s.rise[P_LSO];
		next_s.t_mid = 1'b0;
		next_s.t_slow = 1'b0;
		if (s.rise[P_LSO])
		begin
			next_s.mid_cnt = (s.mid_cnt == MID_LAST) ? 2'h0 : s.mid_cnt + 2'h1;
			next_s.t_mid = (s.mid_cnt == MID_LAST);
			next_s.slow_cnt = (s.slow_cnt == SLOW_LAST) ? 7'h00 : s.slow_cnt + 7'h01;
			next_s.t_slow = (s.slow_cnt == SLOW_LAST);
		end

		// Central tick counter
		next_s.ctc_wake = 1'b0;
		next_s.ctc_irq = 1'b0;
		ctc_mask = CTC_W'((14'h0002 << ctc_period_sel) - 14'h0001);
		if (ctc_clear)
		begin
			next_s.ctc = '0;
		end
		else if (s.t_slow && !hibernate && !debug_halt)
		begin
			next_s.ctc = s.ctc + 13'h0001;
			if ((next_s.ctc & ctc_mask) == '0)
			begin
				next_s.ctc_wake = ctc_wake_en;
				next_s.ctc_irq = ctc_wake_en && ctc_irq_en;
			end
		end

		// Fast tick counter
		next_s.ftc_wake = 1'b0;
		next_s.ftc_irq = 1'b0;
		if (!ftc_enable)
		begin
			next_s.ftc = '0;
		end
		else if (s.t_fast)
		begin
			if (s.ftc >= ftc_terminal)
			begin
				next_s.ftc = '0;
				next_s.ftc_wake = 1'b1;
				next_s.ftc_irq = ftc_irq_en;
			end
			else
			begin
				next_s.ftc = s.ftc + 5'h01;
			end
		end

		// One-second tick from 32768 watch-crystal edges
		next_s.sec_irq = 1'b0;
		if (s.rise[P_WATCH])
		begin
			next_s.sec_cnt = s.sec_cnt + 15'h0001;
			next_s.sec_irq = (s.sec_cnt == SEC_LAST);
		end

		// Doubling takes both edges of a 24 MHz source
		case (usb_src_sel)
			USB_FAB48: next_s.usb_en = s.rise[P_FAB];
			USB_DBL_IMO: next_s.usb_en = s.chg[P_IMO];
			USB_DBL_FAB: next_s.usb_en = s.chg[P_FAB];
			USB_DBL_XTAL: next_s.usb_en = s.chg[P_XTAL];
			default: next_s.usb_en = s.rise[P_FAB];
		endcase

		next_s.bus_clk = bus_out;
		next_s.dig_clk = dig_out;
		next_s.ana_clk = ana_out;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	// Bus divider; the cpu clock is the bus clock itself
	cgd_div_if bus_if ();
	assign bus_if.src_en = {8{s.sys_en}};
	assign bus_if.sel = 3'h0;
	assign bus_if.ratio = bus_ratio;
	assign bus_if.skew = 2'h0;
	assign bus_out = bus_if.clk_out;
	cgd_divider u_bus_div
	(
		.mclk(mclk),
		.sys_rst(sys_rst),
		.d(bus_if)
	);

	genvar g;
	generate
		for (g = 0; g < NUM_DIG; g++)
		begin : g_dig
			cgd_div_if dif ();
			// Inputs: main, crystal, fabric, loop, own aux, chained neighbour, fast tick, system
			assign dif.src_en = {s.sys_en, s.t_fast, dig_tick[(g + NUM_DIG - 1) % NUM_DIG],
				s.rise[P_AUX + g], s.lock & s.pll_tick, s.rise[P_FAB], s.rise[P_XTAL], s.rise[P_IMO]};
			assign dif.sel = dig_sel[g];
			assign dif.ratio = dig_ratio[g];
			assign dif.skew = 2'h0;
			assign dig_out[g] = dif.clk_out;
			assign dig_tick[g] = dif.tick;
			cgd_divider u_div
			(
				.mclk(mclk),
				.sys_rst(sys_rst),
				.d(dif)
			);
		end
		for (g = 0; g < NUM_ANA; g++)
		begin : g_ana
			cgd_div_if aif ();
			assign aif.src_en = {s.sys_en, s.t_fast, dig_tick[g], s.rise[P_WATCH],
				s.lock & s.pll_tick, s.rise[P_FAB], s.rise[P_XTAL], s.rise[P_IMO]};
			assign aif.sel = ana_sel[g];
			assign aif.ratio = ana_ratio[g];
			assign aif.skew = ana_skew[g];
			assign ana_out[g] = aif.clk_out;
			cgd_divider u_div
			(
				.mclk(mclk),
				.sys_rst(sys_rst),
				.d(aif)
			);
		end
	endgenerate

	assign pll_lock = s.lock;
	assign pll_cfg_ok = s.cfg_ok;
	assign pll_lock_irq = s.lock_irq;
	assign pll_clk_en = s.pll_tick;
	assign tick_clock_slow = s.t_slow;
	assign tick_clock_mid = s.t_mid;
	assign tick_clock_fast = s.t_fast;
	assign central_tick_counter = s.ctc;
	assign ctc_wake = s.ctc_wake;
	assign ctc_irq = s.ctc_irq;
	assign fast_tick_count = s.ftc;
	assign ftc_wake = s.ftc_wake;
	assign ftc_irq = s.ftc_irq;
	assign rtc_second_irq = s.sec_irq;
	assign bus_clk = s.bus_clk;
	assign cpu_clk = s.bus_clk;
	assign dig_clk = s.dig_clk;
	assign ana_clk = s.ana_clk;
	assign usb_clk_en = s.usb_en;
endmodule : cgd_clock_gen

// file: cgd_clock_gen_chk.sv
`timescale 1ns/1ns
module cgd_clock_gen_chk
#(
	parameter int unsigned LOCK_CYCLES = 20
)
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic pll_enable,
	input wire logic lock_route_en,
	input wire logic hibernate,
	input wire logic debug_halt,
	input wire logic ctc_clear,
	input wire logic [3:0] ctc_period_sel,
	input wire logic ftc_enable,
	input wire logic ftc_irq_en,
	input wire logic pll_lock,
	input wire logic pll_cfg_ok,
	input wire logic pll_lock_irq,
	input wire logic pll_clk_en,
	input wire logic tick_clock_fast,
	input wire logic tick_clock_mid,
	input wire logic [12:0] central_tick_counter,
	input wire logic ctc_wake,
	input wire logic [4:0] fast_tick_count,
	input wire logic ftc_wake,
	input wire logic ftc_irq,
	input wire logic bus_clk,
	input wire logic cpu_clk
);
	logic [15:0] en_cnt;
	logic [2:0] nf;
	logic mid_seen;
	logic halt;
	logic [12:0] mask;
	assign halt = hibernate | debug_halt;
	assign mask = (13'h0002 << ctc_period_sel) - 13'h0001;
	// Fast ticks since the last mid tick; the first mid tick has no known phase
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			en_cnt <= 16'h0000;
			nf <= 3'h0;
			mid_seen <= 1'b0;
		end
		else
		begin
			if (!pll_enable)
				en_cnt <= 16'h0000;
			else if (en_cnt != 16'hFFFF)
				en_cnt <= en_cnt + 16'h0001;
			if (tick_clock_mid)
				nf <= 3'h0;
			else if (tick_clock_fast)
				nf <= nf + 3'h1;
			if (tick_clock_mid)
				mid_seen <= 1'b1;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_lock_early: assert property (pll_lock |-> en_cnt >= 16'(LOCK_CYCLES))
		else $error("lock too early");
	a_lock_late: assert property (en_cnt == 16'(LOCK_CYCLES + 2) |-> pll_lock)
		else $error("lock too late");
	a_lock_drop: assert property (!pll_enable |=> !pll_lock)
		else $error("lock kept while disabled");
	a_lock_irq: assert property (pll_lock_irq == ($rose(pll_lock) && $past(lock_route_en)))
		else $error("lock irq wrong");
	a_loop_gated: assert property (pll_clk_en |-> pll_cfg_ok && (pll_lock || $past(pll_lock)))
		else $error("loop output before lock");
	a_ctc_clear: assert property (ctc_clear |=> central_tick_counter == 13'h0000)
		else $error("clear ignored");
	a_ctc_hold: assert property ($past(halt) && !$past(ctc_clear) |-> $stable(central_tick_counter))
		else $error("counter moved while halted");
	a_ctc_wake: assert property (ctc_wake |-> (central_tick_counter & mask) == 13'h0000)
		else $error("wake off period");
	a_ftc_wrap: assert property (ftc_wake |-> fast_tick_count == 5'h00)
		else $error("fast counter no wrap");
	a_ftc_irq: assert property (ftc_irq |-> ftc_wake && ftc_irq_en)
		else $error("fast irq wrong");
	a_ftc_off: assert property (!ftc_enable |=> fast_tick_count == 5'h00)
		else $error("fast counter runs disabled");
	a_mid_third: assert property (tick_clock_mid && mid_seen |-> nf + {2'b00, tick_clock_fast} == 3'h3)
		else $error("mid tick not every third");
	a_cpu_bus: assert property (cpu_clk == bus_clk)
		else $error("cpu clock differs");
	c_lock: cover property ($rose(pll_lock));
	c_ctc_wake: cover property (ctc_wake);
	c_ftc_irq: cover property (ftc_irq);
	c_mid: cover property (tick_clock_mid && mid_seen);
endmodule : cgd_clock_gen_chk

bind cgd_clock_gen cgd_clock_gen_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk
(
	.mclk, .sys_rst, .pll_enable, .lock_route_en, .hibernate, .debug_halt, .ctc_clear, .ctc_period_sel,
	.ftc_enable, .ftc_irq_en, .pll_lock, .pll_cfg_ok, .pll_lock_irq, .pll_clk_en, .tick_clock_fast,
	.tick_clock_mid, .central_tick_counter, .ctc_wake, .fast_tick_count, .ftc_wake, .ftc_irq, .bus_clk, .cpu_clk
);

// file: cgd_clock_gen_tb.sv
`timescale 1ns/1ns
module cgd_clock_gen_tb;
	import cgd_pkg::*;
	localparam int LC = 20;
	logic mclk, sys_rst, osc_f, osc_s, pll_enable, lock_route_en, hibernate, debug_halt;
	logic ctc_clear, ctc_wake_en, ctc_irq_en, ftc_enable, ftc_irq_en;
	logic [1:0] pll_ref_sel;
	logic [7:0] pll_ref_mhz;
	logic [5:0] pll_in_div, pll_fb_mult;
	logic [15:0] bus_ratio;
	logic [7:0][2:0] dig_sel;
	logic [7:0][15:0] dig_ratio;
	logic [3:0][2:0] ana_sel;
	logic [3:0][15:0] ana_ratio;
	logic [3:0][1:0] ana_skew;
	logic [3:0] ctc_period_sel;
	logic [4:0] ftc_terminal, fast_tick_count;
	cgd_sys_src_t sys_src_sel;
	cgd_usb_src_t usb_src_sel;
	logic pll_lock, pll_cfg_ok, pll_lock_irq, pll_clk_en, tick_clock_slow, tick_clock_mid, tick_clock_fast;
	logic ctc_wake, ctc_irq, ftc_wake, ftc_irq, bus_clk, cpu_clk, usb_clk_en, rtc_second_irq;
	logic [12:0] central_tick_counter;
	logic [7:0] dig_clk;
	logic [3:0] ana_clk;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;

	// Oscillators run fast so the 1 kHz wheel turns within a short run
	cgd_clock_gen #(.LOCK_CYCLES(LC)) dut
	(
		.mclk, .sys_rst, .internal_main_osc(osc_f), .fast_crystal_osc(osc_f), .fabric_clk(osc_f),
		.fabric_aux_clk({8{osc_f}}), .low_speed_internal_osc(osc_s), .watch_crystal_osc(osc_s), .pll_enable,
		.pll_ref_sel, .pll_ref_mhz, .pll_in_div, .pll_fb_mult, .lock_route_en, .sys_src_sel, .bus_ratio,
		.dig_sel, .dig_ratio, .ana_sel, .ana_ratio, .ana_skew, .usb_src_sel, .hibernate, .debug_halt,
		.ctc_clear, .ctc_wake_en, .ctc_irq_en, .ctc_period_sel, .ftc_enable, .ftc_irq_en, .ftc_terminal,
		.pll_lock, .pll_cfg_ok, .pll_lock_irq, .pll_clk_en, .tick_clock_slow, .tick_clock_mid, .tick_clock_fast,
		.central_tick_counter, .ctc_wake, .ctc_irq, .fast_tick_count, .ftc_wake, .ftc_irq, .rtc_second_irq,
		.bus_clk, .cpu_clk, .dig_clk, .ana_clk, .usb_clk_en
	);

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	initial
	begin
		osc_f = 1'b0;
		osc_s = 1'b0;
		forever
		begin
			@(negedge mclk);
			cyc++;
			if (cyc % 2 == 0)
				osc_f = ~osc_f;
			if (cyc % 4 == 0)
				osc_s = ~osc_s;
			if (cyc == 40000)
			begin
				n_mismatch++;
				stop_test();
			end
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	task cfg_case(input logic [7:0] r, input logic [5:0] d, input logic [5:0] m, input logic e);
		pll_ref_mhz = r;
		pll_in_div = d;
		pll_fb_mult = m;
		repeat (2) @(negedge mclk);
		chk(pll_cfg_ok, e);
	endtask : cfg_case

	task t_pll;
		int i;
		int n;
		int p;
		logic early;
		logic irq;
		for (i = 0; i < 3; i++)
		begin
			cfg_case(8'h03, 6'h00, 6'h10, 1'b1);
			pll_ref_sel = 2'(i);
			lock_route_en = (i != 2);
			pll_enable = 1'b1;
			n = 0;
			early = 1'b0;
			irq = 1'b0;
			while (pll_lock !== 1'b1 && n < 100)
			begin
				@(negedge mclk);
				n++;
				irq = pll_lock_irq;
				if (pll_clk_en === 1'b1 && pll_lock !== 1'b1)
					early = 1'b1;
			end
			chk(n, LC);
			chk(irq, i != 2);
			chk(early, 0);
			p = 0;
			repeat (250)
			begin
				@(negedge mclk);
				p += (pll_clk_en === 1'b1);
			end
			chk(p >= 95 && p <= 97, 1);
			// A change while running must not reach the loop
			pll_fb_mult = 6'h07;
			repeat (2) @(negedge mclk);
			chk(pll_cfg_ok, 1);
			pll_fb_mult = 6'h10;
			pll_enable = 1'b0;
			@(negedge mclk);
			chk(pll_lock, 0);
		end
	endtask : t_pll

	task ctc_pass(input logic ie);
		int i;
		int k;
		int w;
		int q;
		ctc_wake_en = 1'b1;
		ctc_irq_en = ie;
		ctc_clear = 1'b1;
		@(negedge mclk);
		ctc_clear = 1'b0;
		chk(central_tick_counter, 0);
		w = 0;
		q = 0;
		k = 0;
		for (i = 0; i < 2000 && k < 4; i++)
		begin
			@(negedge mclk);
			w += (ctc_wake === 1'b1);
			q += (ctc_irq === 1'b1);
			if (central_tick_counter === 13'h0002)
				k++;
		end
		chk(central_tick_counter, 2);
		chk(w, 1);
		chk(q, ie);
	endtask : ctc_pass

	task t_halt;
		logic [12:0] v;
		chk(pll_lock, 0);
		hibernate = 1'b1;
		repeat (2) @(negedge mclk);
		v = central_tick_counter;
		repeat (1700) @(negedge mclk);
		chk(central_tick_counter, v);
		hibernate = 1'b0;
		debug_halt = 1'b1;
		repeat (1700) @(negedge mclk);
		chk(central_tick_counter, v);
		debug_halt = 1'b0;
		repeat (1600) @(negedge mclk);
		chk(central_tick_counter, v + 13'h0002);
	endtask : t_halt

	task ftc_case(input logic [4:0] t, input logic ie);
		int i;
		int d;
		int q;
		logic [4:0] mx;
		ftc_terminal = t;
		ftc_irq_en = ie;
		ftc_enable = 1'b1;
		for (i = 0; i < 600 && ftc_wake !== 1'b1; i++)
			@(negedge mclk);
		d = 0;
		q = 0;
		mx = 5'h00;
		do
		begin
			@(negedge mclk);
			d++;
			q += (ftc_irq === 1'b1);
			if (fast_tick_count > mx)
				mx = fast_tick_count;
		end
		while (ftc_wake !== 1'b1 && d < 600);
		chk(d, (t + 1) * 8);
		chk(mx, t);
		chk(q, ie);
		ftc_enable = 1'b0;
		repeat (2) @(negedge mclk);
		chk(fast_tick_count, 5'h00);
	endtask : ftc_case

	// Window is a whole number of every output period, so high counts are exact
	task t_div;
		int h [11];
		int e [11];
		int i;
		logic [10:0] v;
		// Far fewer than 32768 watch edges have passed, so no second tick yet
		e = '{1200, 800, 1200, 1200, 1200, 0, 1200, 300, 100, 3, 0};
		h = '{default: 0};
		for (i = 0; i < 2400; i++)
		begin
			@(negedge mclk);
			v = {rtc_second_irq, tick_clock_slow, tick_clock_mid, tick_clock_fast, usb_clk_en, bus_clk !== cpu_clk,
				bus_clk,
				ana_clk[0], dig_clk[2], dig_clk[1], dig_clk[0]};
			foreach (h[j])
				h[j] += (v[j] === 1'b1);
		end
		foreach (h[j])
			chk(h[j], e[j]);
	endtask : t_div

	// Every system and USB source; the loop is off, so the loop choice runs on its reference
	task t_src;
		int i;
		int k;
		int b;
		int u;
		for (k = 0; k < 4; k++)
		begin
			sys_src_sel = cgd_sys_src_t'(2'(k));
			usb_src_sel = cgd_usb_src_t'(2'(k));
			repeat (16) @(negedge mclk);
			b = 0;
			u = 0;
			for (i = 0; i < 800; i++)
			begin
				@(negedge mclk);
				b += (bus_clk === 1'b1);
				u += (usb_clk_en === 1'b1);
			end
			chk(b, 400);
			chk(u, (k == 0) ? 200 : 400);
		end
	endtask : t_src

	initial
	begin
		sys_rst = 1'b1;
		{pll_enable, lock_route_en, hibernate, debug_halt, ctc_clear, ctc_wake_en, ctc_irq_en} = '0;
		{ftc_enable, ftc_irq_en} = '0;
		pll_ref_sel = 2'h0;
		pll_ref_mhz = 8'h03;
		pll_in_div = 6'h00;
		pll_fb_mult = 6'h10;
		sys_src_sel = SYS_IMO;
		usb_src_sel = USB_DBL_IMO;
		bus_ratio = 16'h0002;
		dig_sel = {8{3'h6}};
		dig_ratio = {8{16'h0004}};
		dig_ratio[1] = 16'h0003;
		dig_sel[2] = 3'h5;
		dig_ratio[2] = 16'h0002;
		ana_sel = {4{3'h6}};
		ana_ratio = {4{16'h0004}};
		ana_skew = {4{2'h2}};
		ctc_period_sel = 4'h0;
		ftc_terminal = 5'h00;
		repeat (2) @(negedge mclk);
		sys_rst = 1'b0;
		@(negedge mclk);
		cfg_case(8'h03, 6'h00, 6'h08, 1'b1);
		cfg_case(8'h03, 6'h00, 6'h07, 1'b0);
		cfg_case(8'h43, 6'h00, 6'h01, 1'b1);
		cfg_case(8'h44, 6'h00, 6'h01, 1'b0);
		cfg_case(8'h30, 6'h01, 6'h01, 1'b1);
		cfg_case(8'h03, 6'h00, 6'h00, 1'b0);
		cfg_case(8'h30, 6'h3F, 6'h3F, 1'b1);
		t_pll();
		t_div();
		t_src();
		ctc_pass(1'b1);
		ctc_pass(1'b0);
		t_halt();
		ftc_case(5'h00, 1'b1);
		ftc_case(5'h03, 1'b0);
		ftc_case(5'h1F, 1'b1);
		stop_test();
	end
endmodule : cgd_clock_gen_tb
